/* File: src/ehrc_pkg.sv */
package ehrc_pkg;
    // ------------------------------------------------------------
    // Timing at 25 MHz
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25000000;
    localparam int AUX_RESET_MS = 30;
    localparam int AUX_RESET_CYC = CLK_HZ / 1000 * AUX_RESET_MS;
    // Software reset must exceed 1.5 ms: 1.5 ms in whole cycles, plus one cycle
    localparam int SOFTWARE_RESET_BIT_US = 1500;
    localparam int SOFTWARE_RESET_BIT_CYC = CLK_HZ / 1000000 * SOFTWARE_RESET_BIT_US + 1;
    localparam int INIT_CYC = 16;
    localparam int CNT_W = 24;

    // ------------------------------------------------------------
    // Register offsets (documentation reference only; no bus)
    // ------------------------------------------------------------
    localparam logic [7:0] BRIDGE_STATUS_OFS = 8'h04;
    localparam logic [7:0] SEC_STATUS_OFS = 8'h1c;
    localparam logic [7:0] LINK_CTL_OFS = 8'hc4;
    localparam logic [7:0] LEGACY_MISC_OFS = 8'h40;
    localparam logic [7:0] LEGACY_RESET_OFS = 8'h47;

    // Sticky error status bits
    typedef struct packed {
        logic signaled_target_abort;   // Secondary 0x1c
        logic sec_received_target_abort; // Secondary 0x1c
        logic crc_error_status;        // Link 0xc4
        logic link_failure_status;     // Link 0xc4
        logic flood_seen;              // Bridge 0x04 flood indication
        logic received_master_abort;   // Bridge 0x04
        logic received_target_abort;   // Bridge 0x04
    } ehrc_status_t;

    localparam int ST_W = 7;
    localparam logic [ST_W-1:0] ST_RESET = 7'h00;

    // Auxiliary reset state
    typedef enum logic [1:0] {
        AUX_HOLD = 2'b00,
        AUX_RUN = 2'b01
    } ehrc_aux_state_t;
endpackage

/* File: src/ehrc_top.sv */
`timescale 1ns/1ns
// Functional notes
// RULE1: Auxiliary logic reset pulse lasts about 30 ms after aux power valid.
// RULE2: Aux-domain configuration bits cleared only by the aux reset pulse.
// RULE3: Main power good resets main logic; derives system, init, link resets.
// RULE4: Software reset bit asserts system and link resets longer than 1.5 ms.
// RULE5: Init from keyboard request, fast-init port write, or host shutdown.
// RULE6: Host target/master abort sets status; NMI when enabled.
// RULE7: Link CRC failure sets failure status; floods link when enabled.
// RULE8: Link CRC error sets CRC status; NMI when enabled.
// RULE9: Incoming sync flood resets system when enabled; no status recorded.
// RULE10: Signaled secondary target abort sets status; NMI when enabled.
// RULE11: Received secondary target abort sets status; NMI when enabled.
// RULE12: Tester drives active-low test input low only for test modes.
// RULE13: Outgoing flood also sets bridge status; reset may follow if enabled.
// RULE14: Status bits stay set until cleared; set wins over clear.
module ehrc_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Power and reset sources
    input wire logic aux_power_valid,
    input wire logic main_power_good,
    input wire logic kbd_ctrl_reset_request_n,
    input wire logic test_mode_n,
    // Software controls, synchronous to clk_sys
    input wire logic software_reset_bit,
    input wire logic fast_init_port,
    input wire logic nmi_on_error_enable,
    input wire logic crc_flood_enable,
    input wire logic reset_on_link_error_enable,
    input wire logic [6:0] status_clear,
    // Error events, one-cycle pulses on clk_sys
    input wire logic host_shutdown,
    input wire logic host_target_abort,
    input wire logic host_master_abort,
    input wire logic link_crc_fail,
    input wire logic link_sync_flood_in,
    input wire logic sec_signaled_target_abort,
    input wire logic sec_received_target_abort,
    // Outputs
    output logic aux_reset,
    output logic system_reset_n,
    output logic cpu_init_n,
    output logic host_link_reset_n,
    output logic nmi,
    output logic sync_flood_out,
    output ehrc_pkg::ehrc_status_t status
);
    logic [2:0] aux_sy_q;
    logic [2:0] pg_sy_q;
    logic [2:0] kbd_sy_q;
    logic aux_ok;
    logic pg_ok;
    logic kbd_req;
    logic kbd_seen_q;
    logic main_rst;
    ehrc_pkg::ehrc_aux_state_t aux_st_q;
    logic [ehrc_pkg::CNT_W-1:0] aux_cnt_q;
    logic [ehrc_pkg::CNT_W-1:0] sw_cnt_q;
    logic [ehrc_pkg::CNT_W-1:0] init_cnt_q;
    logic crc_flood_en_q;
    logic rst_on_le_en_q;
    logic flood_q;
    logic sys_rst_req;
    logic [ehrc_pkg::ST_W-1:0] st_q;
    logic [ehrc_pkg::ST_W-1:0] st_set;
    logic nmi_ev;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Three stages; a level counts when the last two agree
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            aux_sy_q <= 3'h0;
            pg_sy_q <= 3'h0;
            kbd_sy_q <= 3'h7;
        end else begin
            aux_sy_q <= {aux_sy_q[1:0], aux_power_valid};
            pg_sy_q <= {pg_sy_q[1:0], main_power_good};
            kbd_sy_q <= {kbd_sy_q[1:0], kbd_ctrl_reset_request_n};
        end
    end
    assign aux_ok = aux_sy_q[1] & aux_sy_q[2];
    assign pg_ok = pg_sy_q[1] & pg_sy_q[2];
    assign kbd_req = ~kbd_sy_q[1] & ~kbd_sy_q[2];
    function automatic logic aux_reset_done(input ehrc_pkg::ehrc_aux_state_t s);
        return s == ehrc_pkg::AUX_RUN;
    endfunction

    // Main logic held while power good is low and until the aux pulse ends
    assign main_rst = ~pg_ok | ~aux_reset_done(aux_st_q); // RULE3

    // ------------------------------------------------------------
    // Auxiliary reset pulse
    // ------------------------------------------------------------
    // Restarts whenever aux power drops, so a glitch gives a full pulse
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            aux_st_q <= ehrc_pkg::AUX_HOLD;
            aux_cnt_q <= '0;
        end else if (!aux_ok) begin
            aux_st_q <= ehrc_pkg::AUX_HOLD;
            aux_cnt_q <= '0;
        end else begin
            case (aux_st_q)
                ehrc_pkg::AUX_HOLD: begin
                    if (aux_cnt_q == ehrc_pkg::CNT_W'(ehrc_pkg::AUX_RESET_CYC - 1)) begin
                        aux_st_q <= ehrc_pkg::AUX_RUN; // RULE1
                    end else begin
                        aux_cnt_q <= aux_cnt_q + 1'b1;
                    end
                end
                ehrc_pkg::AUX_RUN: aux_cnt_q <= aux_cnt_q;
                default: aux_st_q <= ehrc_pkg::AUX_HOLD;
            endcase
        end
    end

    // Aux output straight from a flop
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            aux_reset <= 1'b1;
        end else begin
            aux_reset <= ~(aux_ok && aux_reset_done(aux_st_q));
        end
    end

    // ------------------------------------------------------------
    // Aux-domain configuration
    // ------------------------------------------------------------
    // Link-error enables survive main resets; only the aux pulse clears them
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            crc_flood_en_q <= 1'b0;
            rst_on_le_en_q <= 1'b0;
        end else if (aux_reset) begin
            crc_flood_en_q <= 1'b0; // RULE2
            rst_on_le_en_q <= 1'b0; // RULE2
        end else begin
            crc_flood_en_q <= crc_flood_enable;
            rst_on_le_en_q <= reset_on_link_error_enable;
        end
    end

    // ------------------------------------------------------------
    // Sticky status bits
    // ------------------------------------------------------------
    assign st_set = {sec_signaled_target_abort, sec_received_target_abort,
                     link_crc_fail, link_crc_fail, link_crc_fail & crc_flood_en_q,
                     host_master_abort, host_target_abort};
    // Recorded regardless of enables, except flood_seen, which needs the CRC flood enable; set beats a same-cycle clear
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_q <= ehrc_pkg::ST_RESET;
        end else if (main_rst) begin
            st_q <= ehrc_pkg::ST_RESET;
        end else begin
            st_q <= (st_q & ~status_clear) | st_set; // RULE14 RULE6 RULE7 RULE8 RULE10 RULE11 RULE13
        end
    end

    // ------------------------------------------------------------
    // Handlers
    // ------------------------------------------------------------
    // NMI pulses for host aborts, CRC error and secondary target aborts
    assign nmi_ev = nmi_on_error_enable & (host_target_abort | host_master_abort
                    | link_crc_fail | sec_signaled_target_abort
                    | sec_received_target_abort);
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            nmi <= 1'b0;
        end else begin
            nmi <= nmi_ev & ~main_rst; // RULE6 RULE8 RULE10 RULE11
        end
    end

    // Flood holds until a system reset; the link is unusable afterwards anyway
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            flood_q <= 1'b0;
        end else if (main_rst || sw_cnt_q != '0) begin
            flood_q <= 1'b0;
        end else if (link_crc_fail && crc_flood_en_q) begin
            flood_q <= 1'b1; // RULE7
        end
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync_flood_out <= 1'b0;
        end else begin
            sync_flood_out <= flood_q;
        end
    end

    // ------------------------------------------------------------
    // System and link reset
    // ------------------------------------------------------------
    assign sys_rst_req = software_reset_bit | (link_sync_flood_in & rst_on_le_en_q); // RULE9
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sw_cnt_q <= '0;
        end else if (sys_rst_req && !main_rst) begin
            sw_cnt_q <= ehrc_pkg::CNT_W'(ehrc_pkg::SOFTWARE_RESET_BIT_CYC); // RULE4
        end else if (sw_cnt_q != '0) begin
            sw_cnt_q <= sw_cnt_q - 1'b1;
        end
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            system_reset_n <= 1'b0;
            host_link_reset_n <= 1'b0;
        end else begin
            system_reset_n <= ~main_rst & (sw_cnt_q == '0) & ~sys_rst_req; // RULE3 RULE4
            host_link_reset_n <= ~main_rst & (sw_cnt_q == '0) & ~sys_rst_req; // RULE3 RULE4
        end
    end

    // ------------------------------------------------------------
    // Processor init
    // ------------------------------------------------------------
    // Keyboard request counts on its falling edge only
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            kbd_seen_q <= 1'b0;
        end else begin
            kbd_seen_q <= kbd_req;
        end
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            init_cnt_q <= '0;
        end else if ((kbd_req & ~kbd_seen_q) | fast_init_port | host_shutdown) begin
            init_cnt_q <= ehrc_pkg::CNT_W'(ehrc_pkg::INIT_CYC); // RULE5
        end else if (init_cnt_q != '0) begin
            init_cnt_q <= init_cnt_q - 1'b1;
        end
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cpu_init_n <= 1'b0;
        end else begin
            cpu_init_n <= ~main_rst & (init_cnt_q == '0); // RULE3 RULE5
        end
    end

    // Status drives straight from flops
    assign status = st_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_crc_flood;
        link_crc_fail && crc_flood_en_q && !main_rst && sw_cnt_q == '0;
    endsequence
    property p_flood;
        @(posedge clk_sys) disable iff (reset) s_crc_flood |-> ##2 sync_flood_out;
    endproperty
    a_flood: assert property (p_flood) else $error("flood missing"); // RULE7
    property p_sticky;
        @(posedge clk_sys) disable iff (reset)
            host_target_abort && !main_rst |=> status.received_target_abort;
    endproperty
    a_sticky: assert property (p_sticky) else $error("abort not recorded"); // RULE6
    property p_hold;
        @(posedge clk_sys) disable iff (reset)
            st_q[0] && !status_clear[0] && !main_rst |=> st_q[0];
    endproperty
    a_hold: assert property (p_hold) else $error("status lost"); // RULE14
    property p_nmi;
        @(posedge clk_sys) disable iff (reset)
            link_crc_fail && nmi_on_error_enable && !main_rst |=> nmi;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi missing"); // RULE8
    property p_software_reset_bit;
        @(posedge clk_sys) disable iff (reset)
            software_reset_bit && !main_rst |=> !system_reset_n [*8];
    endproperty
    a_software_reset_bit: assert property (p_software_reset_bit) else $error("reset too short"); // RULE4
    property p_link_rst;
        @(posedge clk_sys) disable iff (reset)
            main_rst |=> !system_reset_n && !host_link_reset_n && !cpu_init_n;
    endproperty
    a_link_rst: assert property (p_link_rst) else $error("reset mismatch"); // RULE3
    property p_init;
        @(posedge clk_sys) disable iff (reset) fast_init_port |=> ##1 !cpu_init_n [*8];
    endproperty
    a_init: assert property (p_init) else $error("init missing"); // RULE5
    property p_sta;
        @(posedge clk_sys) disable iff (reset)
            sec_signaled_target_abort && !main_rst |=> st_q[6];
    endproperty
    a_sta: assert property (p_sta) else $error("sta lost"); // RULE10
    property p_aux;
        @(posedge clk_sys) disable iff (reset) !aux_ok |=> ##1 aux_reset;
    endproperty
    a_aux: assert property (p_aux) else $error("aux reset missing"); // RULE1
endmodule

/* File: testbench/ehrc_host_model.sv */
`timescale 1ns/1ns
module ehrc_host_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Requests from the bench
    input wire logic crc_req,
    input wire logic flood_req,
    // Lines from the hub
    input wire logic nmi,
    // Lines to the hub and counts
    output logic link_crc_fail,
    output logic link_sync_flood_in,
    output logic test_mode_n,
    output logic [7:0] nmi_count
);
    // Link faults are raised only when a scenario asks for them
    assign link_crc_fail = crc_req;
    assign link_sync_flood_in = flood_req;
    // Board keeps the hub in normal operation
    assign test_mode_n = 1'b1;
    // Count interrupt pulses seen by the host
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            nmi_count <= 8'h00;
        end else if (nmi) begin
            nmi_count <= nmi_count + 8'h01;
        end
    end
endmodule

/* File: testbench/tb_ehrc_top.sv */
`timescale 1ns/1ns
module tb_ehrc_top;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic aux_ok = 1'b0;
    logic pgood = 1'b0;
    logic kbd_n = 1'b1;
    logic nmi_en = 1'b0;
    logic cfe = 1'b0;
    logic rle = 1'b0;
    logic [6:0] clr = 7'h00;
    logic [8:0] evt = 9'h000;
    logic aux_reset, sys_n, init_n, link_n, nmi, flood, crc, fin, tmode_n;
    logic [7:0] nmi_cnt;
    ehrc_pkg::ehrc_status_t status;
    int err_total = 0;
    int n_tests = 0;
    int n;
    // ------------------------------------------------------------
    // Clock and instances
    // ------------------------------------------------------------
    always #20 clk_sys = ~clk_sys;
    ehrc_host_model i_ehrc_host_model (.clk_sys(clk_sys), .reset(reset), .crc_req(evt[2]),
        .flood_req(evt[3]), .nmi(nmi), .link_crc_fail(crc), .link_sync_flood_in(fin),
        .test_mode_n(tmode_n), .nmi_count(nmi_cnt));
    ehrc_top i_ehrc_top (.clk_sys(clk_sys), .reset(reset), .aux_power_valid(aux_ok),
        .main_power_good(pgood), .kbd_ctrl_reset_request_n(kbd_n), .test_mode_n(tmode_n),
        .software_reset_bit(evt[8]), .fast_init_port(evt[7]), .nmi_on_error_enable(nmi_en),
        .crc_flood_enable(cfe), .reset_on_link_error_enable(rle), .status_clear(clr),
        .host_shutdown(evt[6]), .host_target_abort(evt[0]), .host_master_abort(evt[1]),
        .link_crc_fail(crc), .link_sync_flood_in(fin), .sec_signaled_target_abort(evt[4]),
        .sec_received_target_abort(evt[5]), .aux_reset(aux_reset), .system_reset_n(sys_n),
        .cpu_init_n(init_n), .host_link_reset_n(link_n), .nmi(nmi), .sync_flood_out(flood),
        .status(status));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Inputs always move 1 ns after the edge
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One-cycle event; returns just after the sampling edge
    task automatic pulse(input int idx);
        evt[idx] = 1'b1;
        tick();
        evt[idx] = 1'b0;
    endtask
    task automatic clear_all;
        clr = 7'h7f;
        tick();
        clr = 7'h00;
    endtask
    // Wait while a line sits at lvl, counting cycles; a run reaching lim cycles ends the test
    task automatic hold(input logic lvl, input bit which, input int lim, output int cnt);
        cnt = 0;
        while (((which ? init_n : sys_n) === lvl) && cnt < lim) begin
            tick();
            cnt++;
        end
        if (cnt >= lim) begin
            err_total++;
            $display("[FAIL] wait expected done seen timeout");
            stop_test();
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_power;
        repeat (2) @(posedge clk_sys);
        #1 reset = 1'b0;
        aux_ok = 1'b1;
        pgood = 1'b1;
        n = 0;
        while (aux_reset !== 1'b0 && n < 760000) begin
            tick();
            n++;
        end
        check("aux_len_ok", 8'h01, 8'(n >= 750000 && n <= 750010));
        hold(1'b0, 1'b0, 8, n);
        check("link_n", 8'h01, 8'(link_n));
        check("init_n", 8'h01, 8'(init_n));
        pgood = 1'b0;
        hold(1'b1, 1'b0, 8, n);
        check("sys_n_drop", 8'h00, 8'(sys_n));
        check("link_n_drop", 8'h00, 8'(link_n));
        check("init_n_drop", 8'h00, 8'(init_n));
        pgood = 1'b1;
        hold(1'b0, 1'b0, 8, n);
    endtask
    task automatic t_aborts;
        pulse(0);
        check("rta", 8'h01, 8'(status.received_target_abort));
        check("nmi_off", 8'h00, 8'(nmi));
        nmi_en = 1'b1;
        pulse(1);
        check("rma", 8'h01, 8'(status.received_master_abort));
        check("nmi_rma", 8'h01, 8'(nmi));
        tick();
        check("nmi_one", 8'h00, 8'(nmi));
        check("rta_stands", 8'h01, 8'(status.received_target_abort));
        pulse(4);
        check("sta", 8'h01, 8'(status.signaled_target_abort));
        check("nmi_sta", 8'h01, 8'(nmi));
        pulse(5);
        check("srta", 8'h01, 8'(status.sec_received_target_abort));
        check("nmi_srta", 8'h01, 8'(nmi));
        tick();
        check("nmi_count", 8'h03, nmi_cnt);
        clear_all();
        check("cleared", 8'h00, 8'(status));
    endtask
    task automatic t_crc;
        // Enables are registered, so give them an edge before the events
        cfe = 1'b1;
        rle = 1'b1;
        tick();
        pulse(2);
        check("crc_bits", 8'h1c, 8'(status));
        check("nmi_crc", 8'h01, 8'(nmi));
        check("flood_c1", 8'h00, 8'(flood));
        tick();
        check("flood_c2", 8'h01, 8'(flood));
        clear_all();
        check("flood_level", 8'h01, 8'(flood));
        pulse(3);
        hold(1'b1, 1'b0, 4, n);
        check("sys_n_flood", 8'h00, 8'(sys_n));
        check("no_status", 8'h00, 8'(status));
        hold(1'b0, 1'b0, 40000, n);
        check("flood_ends", 8'h00, 8'(flood));
        rle = 1'b0;
    endtask
    task automatic t_software_reset_bit;
        pulse(8);
        check("sys_n_sw", 8'h00, 8'(sys_n));
        check("link_n_sw", 8'h00, 8'(link_n));
        hold(1'b0, 1'b0, 40000, n);
        check("sw_len_ok", 8'h01, 8'(n >= 37500));
        check("link_n_back", 8'h01, 8'(link_n));
        // Flood enable lives in the aux domain and survives main resets
        pulse(2);
        tick();
        check("flood_kept", 8'h01, 8'(flood));
    endtask
    task automatic t_init(input int idx);
        if (idx < 9) begin
            pulse(idx);
        end else begin
            kbd_n = 1'b0;
        end
        hold(1'b1, 1'b1, 12, n);
        hold(1'b0, 1'b1, 40, n);
        kbd_n = 1'b1;
        check("init_len_ok", 8'h01, 8'(n >= 15 && n <= 18));
        check("no_sys_rst", 8'h01, 8'(sys_n));
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        t_power();
        t_aborts();
        t_crc();
        t_software_reset_bit();
        t_init(6);
        t_init(7);
        t_init(9);
        stop_test();
    end
endmodule
